// ===== mcr_core_map.vh
`ifndef MCR_CORE_MAP_VH
`define MCR_CORE_MAP_VH

// Register addresses on the core's register port
`define MCR_ADDR_PORT0_LATCH 8'h80
`define MCR_ADDR_STACK_POINTER 8'h81
`define MCR_ADDR_DPTR0_LOW 8'h82
`define MCR_ADDR_DPTR0_HIGH 8'h83
`define MCR_ADDR_DPTR1_LOW 8'h84
`define MCR_ADDR_DPTR1_HIGH 8'h85
`define MCR_ADDR_STRETCH_CTRL 8'h8E
`define MCR_ADDR_PORT1_LATCH 8'h90
`define MCR_ADDR_PORT1_DIR 8'h91
`define MCR_ADDR_PORT2_LATCH 8'hA0
`define MCR_ADDR_PORT2_DIR 8'hA1
`define MCR_ADDR_PORT0_DIR 8'hA2
`define MCR_ADDR_STATUS_WORD 8'hD0

// Status word field positions
`define MCR_PSW_CARRY 7
`define MCR_PSW_AUX_CARRY 6
`define MCR_PSW_USER_FLAG0 5
`define MCR_PSW_BANK_HIGH 4
`define MCR_PSW_BANK_LOW 3
`define MCR_PSW_OVERFLOW 2
`define MCR_PSW_USER_FLAG1 1
`define MCR_PSW_PARITY 0

// Stretch field position and width
`define MCR_STRETCH_MSB 2
`define MCR_STRETCH_LSB 0

// Reset values
`define MCR_RST_STACK_POINTER 8'h07
`define MCR_RST_PORT_LATCH 8'hFF
`define MCR_RST_PORT_DIR 8'h00
`define MCR_RST_DATA_PTR0 8'h00
`define MCR_RST_STATUS_WORD 8'h00
`define MCR_RST_PROGRAM_COUNTER 16'h0000
`define MCR_RST_STRETCH 3'h1

// Memory cycle timing, in MPU clock cycles beyond the stretch value, except the write strobe minimum, which is a floor
`define MCR_RD_EXTRA_CYCLES 4'h1
`define MCR_WR_ADDR_EXTRA_CYCLES 4'h2
`define MCR_WR_STROBE_MIN 4'h1

`endif

// ===== mcr_xmem_cycle.v
`include "mcr_core_map.vh"

module mcr_xmem_cycle #(
  parameter ADDR_W = 16,
  parameter DATA_W = 8
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Request from the core
  input wire start_rd,
  input wire start_wr,
  input wire [2:0] stretch,
  input wire [ADDR_W-1:0] req_addr,
  input wire [DATA_W-1:0] req_wdata,
  // Shared data memory strobes
  output reg [ADDR_W-1:0] mem_addr_r,
  output reg [DATA_W-1:0] mem_wdata_r,
  output reg mem_addr_valid_r,
  output reg mem_rd_r,
  output reg mem_wr_r,
  output reg busy_r,
  output reg done_r
);

  localparam ST_IDLE = 2'd0;
  localparam ST_READ = 2'd1;
  localparam ST_WRITE = 2'd2;

  reg [1:0] state_r; // Cycle state
  reg [3:0] cnt_r; // Cycle index within the address window
  reg [3:0] last_r; // Index of the last address cycle
  reg [3:0] wr_last_r; // Index of the last write strobe cycle
  wire [3:0] n_ext; // Stretch value widened to the counter

  assign n_ext = {1'b0, stretch};

  // Strobe sequencer; requests while busy are ignored
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      last_r <= 4'h0;
      wr_last_r <= 4'h0;
      mem_addr_r <= {ADDR_W{1'b0}};
      mem_wdata_r <= {DATA_W{1'b0}};
      mem_addr_valid_r <= 1'b0;
      mem_rd_r <= 1'b0;
      mem_wr_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          cnt_r <= 4'h0;
          if (start_rd) begin
            // Address and read strobe both last N+1 cycles
            state_r <= ST_READ;
            last_r <= n_ext + `MCR_RD_EXTRA_CYCLES - 4'h1;
            mem_addr_r <= req_addr;
            mem_addr_valid_r <= 1'b1;
            mem_rd_r <= 1'b1;
            busy_r <= 1'b1;
          end else if (start_wr) begin
            // Address lasts N+2 cycles, strobe N cycles but never under one
            state_r <= ST_WRITE;
            last_r <= n_ext + `MCR_WR_ADDR_EXTRA_CYCLES - 4'h1;
            wr_last_r <= (n_ext == 4'h0) ? `MCR_WR_STROBE_MIN : n_ext;
            mem_addr_r <= req_addr;
            mem_wdata_r <= req_wdata;
            mem_addr_valid_r <= 1'b1;
            busy_r <= 1'b1;
          end
        end
        ST_READ: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == last_r) begin
            // Window closes; the read data is sampled in this last cycle
            state_r <= ST_IDLE;
            mem_addr_valid_r <= 1'b0;
            mem_rd_r <= 1'b0;
            busy_r <= 1'b0;
            done_r <= 1'b1;
          end
        end
        ST_WRITE: begin
          cnt_r <= cnt_r + 4'h1;
          // Strobe sits inside the window so address is stable at both edges
          mem_wr_r <= (cnt_r < wr_last_r);
          if (cnt_r == last_r) begin
            state_r <= ST_IDLE;
            mem_addr_valid_r <= 1'b0;
            mem_wr_r <= 1'b0;
            busy_r <= 1'b0;
            done_r <= 1'b1;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          mem_addr_valid_r <= 1'b0;
          mem_rd_r <= 1'b0;
          mem_wr_r <= 1'b0;
          busy_r <= 1'b0;
        end
      endcase
    end
  end

endmodule // mcr_xmem_cycle

// ===== mcr_core_regs.v
`include "mcr_core_map.vh"

// This block holds the programmer-visible state of the core.
// The instruction decoder drives the register port and the flow strobes.
// Everything here runs on clk_sys, with one asynchronous reset.
// Outputs are registered so that the rest of the core sees clean levels.
// Limitation: there is no atomic sixteen-bit pointer write.
// Software must write both pointer bytes on its own.
// Limitation: the stretch field is not checked for safe values.
// The decoder must not raise both push and pop in one cycle.
// If it does, the push wins and the pop is lost.
module mcr_core_regs #(
  parameter PORT_W = 8,
  parameter ADDR_W = 16
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Register port from the instruction decoder
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata_r,
  // Accumulator and ALU flag results
  input wire [7:0] acc_value,
  input wire flag_we,
  input wire carry_in,
  input wire aux_carry_in,
  input wire overflow_in,
  // Stack and program flow
  input wire stack_push,
  input wire stack_pop,
  input wire pc_fetch,
  input wire pc_load,
  input wire [ADDR_W-1:0] pc_load_value,
  // Data pointer select and external data requests
  input wire data_ptr0_sel,
  input wire xmem_rd_req,
  input wire xmem_wr_req,
  input wire [7:0] xmem_wdata,
  // Core state seen by the rest of the core
  output reg [1:0] bank_select_r,
  output reg [7:0] stack_pointer_r,
  output reg [ADDR_W-1:0] program_counter_r,
  output reg [ADDR_W-1:0] code_index_addr_r,
  // Digital pins
  input wire [PORT_W-1:0] port0_pin_in,
  input wire [PORT_W-1:0] port1_pin_in,
  input wire [PORT_W-1:0] port2_pin_in,
  output reg [PORT_W-1:0] port0_latch_r,
  output reg [PORT_W-1:0] port1_latch_r,
  output reg [PORT_W-1:0] port2_latch_r,
  output reg [PORT_W-1:0] port0_direction_r,
  output reg [PORT_W-1:0] port1_direction_r,
  output reg [PORT_W-1:0] port2_direction_r,
  // Shared data memory cycle
  output wire [ADDR_W-1:0] mem_addr_r,
  output wire [7:0] mem_wdata_r,
  output wire mem_addr_valid_r,
  output wire mem_rd_r,
  output wire mem_wr_r,
  output wire xmem_busy_r,
  output wire xmem_done_r
);

  // Status word flags are kept as single bits.
  // That lets hardware updates touch a flag without the rest of the word.
  reg carry_flag_r; // Arithmetic carry
  reg aux_carry_flag_r; // Nibble carry for decimal adjust
  reg user_flag_zero_r; // Software flag
  reg user_flag_one_r; // Second software flag
  reg overflow_flag_r; // Signed overflow
  reg parity_flag_r; // Even parity over the accumulator
  // Pointer bytes are stored apart, since software loads them apart
  reg [7:0] data_ptr0_low_r; // First pointer, low byte
  reg [7:0] data_ptr0_high_r; // First pointer, high byte
  reg [7:0] data_ptr1_low_r; // Second pointer, low byte
  reg [7:0] data_ptr1_high_r; // Second pointer, high byte
  reg [2:0] stretch_r; // Extra cycles per data memory access
  wire [ADDR_W-1:0] data_ptr0_active; // Pointer chosen for this access
  wire [7:0] status_word; // Assembled status word
  reg [7:0] rdata_nxt; // Read mux result
  wire [ADDR_W-1:0] acc_wide; // Accumulator widened for indexing

  // Register write decode, shared by every write process.
  // A single function keeps each address match written the same way,
  // so a typo in one process cannot make a register alias another.
  function is_wr;
    input [7:0] addr;
    input [7:0] target;
    input we;
    begin
      is_wr = we && (addr == target);
    end
  endfunction

  // Status word assembled from its flags, most significant bit first.
  // The two bank bits sit in the middle of the word.
  assign status_word = {carry_flag_r, aux_carry_flag_r, user_flag_zero_r, bank_select_r,
                        overflow_flag_r, user_flag_one_r, parity_flag_r};
  assign data_ptr0_active = data_ptr0_sel ? {data_ptr1_high_r, data_ptr1_low_r}
                                : {data_ptr0_high_r, data_ptr0_low_r};
  // Pointer chosen by the select level, shared by code and data accesses.
  // Zero-extend the accumulator to the address width for indexing.
  assign acc_wide = {{(ADDR_W-8){1'b0}}, acc_value};

  // Status word: ALU results beat a software write in the same cycle.
  // The later assignment wins, so the ALU block sits below the write.
  // Bank bits only change by a software write.
  // The bank base is bank times eight in the internal data space.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      carry_flag_r <= 1'b0;
      aux_carry_flag_r <= 1'b0;
      user_flag_zero_r <= 1'b0;
      bank_select_r <= 2'b00;
      overflow_flag_r <= 1'b0;
      user_flag_one_r <= 1'b0;
      parity_flag_r <= 1'b0;
    end else begin
      // Parity follows the accumulator every cycle and ignores writes
      parity_flag_r <= ^acc_value;
      if (is_wr(sfr_addr, `MCR_ADDR_STATUS_WORD, sfr_wr)) begin
        carry_flag_r <= sfr_wdata[`MCR_PSW_CARRY];
        aux_carry_flag_r <= sfr_wdata[`MCR_PSW_AUX_CARRY];
        user_flag_zero_r <= sfr_wdata[`MCR_PSW_USER_FLAG0];
        bank_select_r <= {sfr_wdata[`MCR_PSW_BANK_HIGH], sfr_wdata[`MCR_PSW_BANK_LOW]};
        overflow_flag_r <= sfr_wdata[`MCR_PSW_OVERFLOW];
        user_flag_one_r <= sfr_wdata[`MCR_PSW_USER_FLAG1];
      end
      if (flag_we) begin
        // Hardware flag update wins over a software write
        carry_flag_r <= carry_in;
        aux_carry_flag_r <= aux_carry_in;
        overflow_flag_r <= overflow_in;
      end
    end
  end

  // Stack pointer: software write wins, else pre-increment on push.
  // Wrap from the top of the byte is silent; software owns the depth.
  // After reset the first pushed byte lands one above the reset value.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stack_pointer_r <= `MCR_RST_STACK_POINTER;
    end else if (is_wr(sfr_addr, `MCR_ADDR_STACK_POINTER, sfr_wr)) begin
      stack_pointer_r <= sfr_wdata;
    end else if (stack_push) begin
      // Push writes memory at the new value, one cycle later
      stack_pointer_r <= stack_pointer_r + 8'h01;
    end else if (stack_pop) begin
      stack_pointer_r <= stack_pointer_r - 8'h01;
    end
  end

  // Data pointer bytes, each an ordinary register.
  // A byte written while a memory cycle runs does not move that cycle,
  // because the cycle generator latched its address at the request.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      data_ptr0_low_r <= `MCR_RST_DATA_PTR0;
      data_ptr0_high_r <= `MCR_RST_DATA_PTR0;
      data_ptr1_low_r <= `MCR_RST_DATA_PTR0;
      data_ptr1_high_r <= `MCR_RST_DATA_PTR0;
    end else begin
      if (is_wr(sfr_addr, `MCR_ADDR_DPTR0_LOW, sfr_wr)) begin
        data_ptr0_low_r <= sfr_wdata;
      end
      if (is_wr(sfr_addr, `MCR_ADDR_DPTR0_HIGH, sfr_wr)) begin
        data_ptr0_high_r <= sfr_wdata;
      end
      if (is_wr(sfr_addr, `MCR_ADDR_DPTR1_LOW, sfr_wr)) begin
        data_ptr1_low_r <= sfr_wdata;
      end
      if (is_wr(sfr_addr, `MCR_ADDR_DPTR1_HIGH, sfr_wr)) begin
        data_ptr1_high_r <= sfr_wdata;
      end
    end
  end

  // Indexed code address is registered, so it trails the pointer by a cycle.
  // The register keeps the adder off the code memory address path.
  // The decoder must allow for the extra cycle of lag.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      code_index_addr_r <= {ADDR_W{1'b0}};
    end else begin
      code_index_addr_r <= data_ptr0_active + acc_wide;
    end
  end

  // Program counter: a jump load takes priority over the increment.
  // A load and a fetch in one cycle land on the load target.
  // The counter wraps silently at the top of code space.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      program_counter_r <= `MCR_RST_PROGRAM_COUNTER;
    end else if (pc_load) begin
      program_counter_r <= pc_load_value;
    end else if (pc_fetch) begin
      // One step per opcode or operand byte read from code memory
      program_counter_r <= program_counter_r + {{(ADDR_W-1){1'b0}}, 1'b1};
    end
  end

  // Port latches and direction registers.
  // Latches reset high and directions low, so pins start undriven.
  // That keeps the board safe until software chooses outputs.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      port0_latch_r <= {PORT_W{1'b1}};
      port1_latch_r <= {PORT_W{1'b1}};
      port2_latch_r <= {PORT_W{1'b1}};
      port0_direction_r <= {PORT_W{1'b0}};
      port1_direction_r <= {PORT_W{1'b0}};
      port2_direction_r <= {PORT_W{1'b0}};
    end else begin
      // Latch bits go straight to the pin drivers
      if (is_wr(sfr_addr, `MCR_ADDR_PORT0_LATCH, sfr_wr)) begin
        port0_latch_r <= sfr_wdata[PORT_W-1:0];
      end
      if (is_wr(sfr_addr, `MCR_ADDR_PORT1_LATCH, sfr_wr)) begin
        port1_latch_r <= sfr_wdata[PORT_W-1:0];
      end
      if (is_wr(sfr_addr, `MCR_ADDR_PORT2_LATCH, sfr_wr)) begin
        port2_latch_r <= sfr_wdata[PORT_W-1:0];
      end
      // Direction bits are the pin output enables
      if (is_wr(sfr_addr, `MCR_ADDR_PORT0_DIR, sfr_wr)) begin
        port0_direction_r <= sfr_wdata[PORT_W-1:0];
      end
      if (is_wr(sfr_addr, `MCR_ADDR_PORT1_DIR, sfr_wr)) begin
        port1_direction_r <= sfr_wdata[PORT_W-1:0];
      end
      if (is_wr(sfr_addr, `MCR_ADDR_PORT2_DIR, sfr_wr)) begin
        port2_direction_r <= sfr_wdata[PORT_W-1:0];
      end
    end
  end

  // Stretch field; any value is accepted, though only the reset value
  // keeps the shared memory arbitration safe.
  // Upper bits of the byte are dropped and read back as zero.
  // A new value only applies to the next memory request.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      // Reset value is the one that keeps shared memory access safe
      stretch_r <= `MCR_RST_STRETCH;
    end else if (is_wr(sfr_addr, `MCR_ADDR_STRETCH_CTRL, sfr_wr)) begin
      stretch_r <= sfr_wdata[`MCR_STRETCH_MSB:`MCR_STRETCH_LSB];
    end
  end

  // Read mux; unmapped addresses read as zero.
  // The parity bit in the status word is read, never written.
  // Port reads return pin levels, so undriven pins show the board.
  always @* begin
    rdata_nxt = 8'h00;
    case (sfr_addr)
      // Ports read the pins, not the latch, so output pins read back too
      `MCR_ADDR_PORT0_LATCH: rdata_nxt = port0_pin_in;
      `MCR_ADDR_PORT1_LATCH: rdata_nxt = port1_pin_in;
      `MCR_ADDR_PORT2_LATCH: rdata_nxt = port2_pin_in;
      `MCR_ADDR_PORT0_DIR: rdata_nxt = port0_direction_r;
      `MCR_ADDR_PORT1_DIR: rdata_nxt = port1_direction_r;
      `MCR_ADDR_PORT2_DIR: rdata_nxt = port2_direction_r;
      `MCR_ADDR_STACK_POINTER: rdata_nxt = stack_pointer_r;
      `MCR_ADDR_DPTR0_LOW: rdata_nxt = data_ptr0_low_r;
      `MCR_ADDR_DPTR0_HIGH: rdata_nxt = data_ptr0_high_r;
      `MCR_ADDR_DPTR1_LOW: rdata_nxt = data_ptr1_low_r;
      `MCR_ADDR_DPTR1_HIGH: rdata_nxt = data_ptr1_high_r;
      `MCR_ADDR_STRETCH_CTRL: rdata_nxt = {5'h00, stretch_r};
      `MCR_ADDR_STATUS_WORD: rdata_nxt = status_word;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Read data is registered and holds until the next read.
  // Holding it lets the decoder take the byte a cycle late.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sfr_rdata_r <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata_r <= rdata_nxt;
    end
  end

  // Data memory cycle generator, addressed by the selected pointer.
  // It latches address, data and stretch at the request edge.
  // Requests while it is busy are dropped, so the decoder must wait
  // for the done pulse before it asks again.
  mcr_xmem_cycle #(
    .ADDR_W(ADDR_W),
    .DATA_W(8)
  ) u_xmem (
    .clk_sys(clk_sys),
    .rst(rst),
    .start_rd(xmem_rd_req),
    .start_wr(xmem_wr_req),
    .stretch(stretch_r),
    .req_addr(data_ptr0_active),
    .req_wdata(xmem_wdata),
    .mem_addr_r(mem_addr_r),
    .mem_wdata_r(mem_wdata_r),
    .mem_addr_valid_r(mem_addr_valid_r),
    .mem_rd_r(mem_rd_r),
    .mem_wr_r(mem_wr_r),
    .busy_r(xmem_busy_r),
    .done_r(xmem_done_r)
  );

endmodule // mcr_core_regs

// ===== mcr_pin_model.sv
// Pins seen from outside: a driven pin follows its latch, an undriven pin
// shows the external level, so a port read can tell pin from latch
module mcr_pin_model (
  // Core side, ports 2..0 packed high to low
  input wire [23:0] latch_all,
  input wire [23:0] dir_all,
  // External drivers on the board
  input wire [23:0] ext_all,
  // Resolved pin levels
  output wire [23:0] pin_all
);
  timeunit 1ns;
  timeprecision 1ns;
  // Direction one lets the latch drive, zero leaves the board level
  assign pin_all = (dir_all & latch_all) | (~dir_all & ext_all);
endmodule // mcr_pin_model

// ===== mcr_core_monitor.sv
module mcr_core_monitor #(
  parameter ADDR_W = 16
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Register port
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata_r,
  input wire [7:0] acc_value,
  // Program flow
  input wire stack_push,
  input wire stack_pop,
  input wire pc_fetch,
  input wire pc_load,
  input wire [7:0] stack_pointer_r,
  input wire [ADDR_W-1:0] program_counter_r,
  input wire [1:0] bank_select_r,
  // Pins
  input wire [7:0] port1_pin_in,
  input wire [7:0] port0_latch_r,
  input wire [7:0] port0_direction_r,
  // Data memory cycle
  input wire xmem_rd_req,
  input wire xmem_wr_req,
  input wire xmem_busy_r,
  input wire xmem_done_r,
  input wire mem_addr_valid_r,
  input wire mem_rd_r,
  input wire mem_wr_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  reg [2:0] str_q; // Stretch field as last written
  reg [2:0] str_cyc; // Stretch taken with the running cycle
  reg wr_cyc; // Running cycle is a write
  reg [3:0] rd_n, wr_n, av_n; // Strobe widths so far
  // Mirror the stretch field and measure strobe widths
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      str_q <= 3'h1;
      str_cyc <= 3'h1;
      wr_cyc <= 1'b0;
      rd_n <= 4'h0;
      wr_n <= 4'h0;
      av_n <= 4'h0;
    end else begin
      if (sfr_wr && sfr_addr == 8'h8E) str_q <= sfr_wdata[2:0];
      // Requests while busy are dropped, so only idle ones restart the mirror
      if ((xmem_rd_req || xmem_wr_req) && !xmem_busy_r) begin
        str_cyc <= str_q;
        wr_cyc <= !xmem_rd_req;
      end
      rd_n <= mem_rd_r ? rd_n + 4'h1 : 4'h0;
      wr_n <= mem_wr_r ? wr_n + 4'h1 : 4'h0;
      av_n <= mem_addr_valid_r ? av_n + 4'h1 : 4'h0;
    end
  end
  a_reset_vals: assert property ($fell(rst) |-> stack_pointer_r == 8'h07 && program_counter_r == 0
    && port0_latch_r == 8'hFF && port0_direction_r == 8'h00) else $error("reset values wrong");
  a_push_incr: assert property (stack_push && !stack_pop && !(sfr_wr && sfr_addr == 8'h81)
    |=> stack_pointer_r == $past(stack_pointer_r) + 8'h01) else $error("push did not increment");
  a_pc_advance: assert property (pc_fetch && !pc_load
    |=> program_counter_r == $past(program_counter_r) + 1'b1) else $error("fetch did not advance");
  a_bank_write: assert property (sfr_wr && sfr_addr == 8'hD0
    |=> bank_select_r == $past(sfr_wdata[4:3])) else $error("bank select not loaded");
  a_dir_write: assert property (sfr_wr && sfr_addr == 8'hA2
    |=> port0_direction_r == $past(sfr_wdata)) else $error("direction not loaded");
  a_pin_read: assert property (sfr_rd && sfr_addr == 8'h90
    |=> sfr_rdata_r == $past(port1_pin_in)) else $error("port read not pin level");
  a_parity_even: assert property (sfr_rd && sfr_addr == 8'hD0 && $stable(acc_value) && !$past(rst)
    |=> sfr_rdata_r[0] == ^$past(acc_value)) else $error("parity bit wrong");
  a_rd_width: assert property ($fell(mem_rd_r) |-> rd_n == {1'b0, str_cyc} + 4'h1)
    else $error("read strobe width wrong");
  a_addr_width: assert property ($fell(mem_addr_valid_r)
    |-> av_n == {1'b0, str_cyc} + (wr_cyc ? 4'h2 : 4'h1)) else $error("address width wrong");
  a_wr_width: assert property ($fell(mem_wr_r)
    |-> wr_n == (str_cyc == 3'h0 ? 4'h1 : {1'b0, str_cyc})) else $error("write strobe width wrong");
  a_done_after: assert property ($fell(mem_addr_valid_r) |-> xmem_done_r) else $error("no done after window");
endmodule // mcr_core_monitor
bind mcr_core_regs mcr_core_monitor #(.ADDR_W(ADDR_W)) mcr_core_monitor_inst (.*);

// ===== tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // Stimulus
  reg clk_sys = 1'b0, rst = 1'b1;
  reg [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, acc_value = 8'h00, xmem_wdata = 8'h00, v;
  reg sfr_wr = 0, sfr_rd = 0, flag_we = 0, carry_in = 0, aux_carry_in = 0, overflow_in = 0;
  reg stack_push = 0, stack_pop = 0, pc_fetch = 0, pc_load = 0, data_ptr0_sel = 0, xmem_rd_req = 0, xmem_wr_req = 0;
  reg [15:0] pc_load_value = 16'h0000, dp0 = 16'h0000, dp1 = 16'h0000;
  reg [23:0] ext_all = 24'h000000, tl = 24'hFFFFFF, td = 24'h000000;
  reg [31:0] lf = 32'd94622; // Fixed seed keeps runs repeatable
  integer error_cnt = 0, n_checks = 0, i, k;
  // Design outputs
  wire [7:0] sfr_rdata_r, stack_pointer_r, mem_wdata_r;
  wire [7:0] port0_latch_r, port1_latch_r, port2_latch_r, port0_direction_r, port1_direction_r, port2_direction_r;
  wire [1:0] bank_select_r;
  wire [15:0] program_counter_r, code_index_addr_r, mem_addr_r;
  wire mem_addr_valid_r, mem_rd_r, mem_wr_r, xmem_busy_r, xmem_done_r;
  wire [23:0] pin_all;
  localparam [63:0] RW_TAB = 64'h818283848591A1A2; // Plain read-write places
  always #50 clk_sys = ~clk_sys;
  mcr_core_regs mcr_core_regs_inst (.*, .port0_pin_in(pin_all[7:0]), .port1_pin_in(pin_all[15:8]),
    .port2_pin_in(pin_all[23:16]));
  mcr_pin_model mcr_pin_model_inst (.latch_all({port2_latch_r, port1_latch_r, port0_latch_r}),
    .dir_all({port2_direction_r, port1_direction_r, port0_direction_r}), .ext_all(ext_all), .pin_all(pin_all));
  // Random source
  task rnd(output [7:0] r);
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    r = lf[7:0];
  endtask
  task chk(input string name, input [15:0] seen, input [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Register port cycles, driven on the falling edge
  task wr(input [7:0] a, input [7:0] d);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1;
    @(negedge clk_sys);
    sfr_wr = 0;
  endtask
  task rdchk(input [7:0] a, input [7:0] e);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_rd = 1;
    @(negedge clk_sys);
    sfr_rd = 0;
    chk($sformatf("sfr_%h", a), sfr_rdata_r, e);
  endtask
  // One data memory cycle; a read request during busy must be dropped
  task xfer(input w, input [2:0] n);
    integer c, rdc, wrc, avc;
    reg [15:0] ad;
    rdc = 0; wrc = 0; avc = 0; ad = 16'h0000;
    @(negedge clk_sys);
    if (w) xmem_wr_req = 1;
    else xmem_rd_req = 1;
    @(negedge clk_sys);
    xmem_wr_req = 0;
    xmem_rd_req = 1;
    for (c = 0; c < 20 && xmem_done_r !== 1'b1; c++) begin
      rdc += mem_rd_r;
      wrc += mem_wr_r;
      avc += mem_addr_valid_r;
      if (c == 0) ad = mem_addr_r;
      @(negedge clk_sys);
      xmem_rd_req = 0;
    end
    chk("done", xmem_done_r, 1);
    chk("mem_rd", rdc, w ? 0 : n + 1);
    chk("addr_valid", avc, n + (w ? 2 : 1));
    chk("mem_wr", wrc, w ? (n == 0 ? 1 : n) : 0);
    chk("mem_addr", ad, data_ptr0_sel ? dp1 : dp0);
    if (w) chk("wdata", mem_wdata_r, xmem_wdata);
  endtask
  task conclude;
    if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (10) @(negedge clk_sys);
    rst = 0;
    rdchk(8'h81, 8'h07);
    rdchk(8'h8E, 8'h01);
    chk("pc", program_counter_r, 16'h0000);
    chk("latch01", {port0_latch_r, port1_latch_r}, 16'hFFFF);
    chk("latch2_port0_direction", {port2_latch_r, port0_direction_r}, 16'hFF00);
    chk("dir12", {port1_direction_r, port2_direction_r}, 16'h0000);
    stack_push = 1;
    @(negedge clk_sys);
    stack_push = 0;
    chk("sp_push", stack_pointer_r, 8'h08);
    pc_fetch = 1;
    repeat (3) @(negedge clk_sys);
    pc_fetch = 0;
    chk("pc_fetch", program_counter_r, 16'h0003);
    // Random write then read back of each plain register
    for (i = 0; i < 8; i++) begin
      rnd(v);
      k = RW_TAB[63-8*i -: 8];
      wr(k, v);
      rdchk(k, v);
      case (k)
        8'h82: dp0[7:0] = v;
        8'h83: dp0[15:8] = v;
        8'h84: dp1[7:0] = v;
        8'h85: dp1[15:8] = v;
        8'h91: td[15:8] = v;
        8'hA1: td[23:16] = v;
        8'hA2: td[7:0] = v;
        default: ;
      endcase
    end
    // Latches with mixed directions, board drives the rest
    rnd(v);
    ext_all = {v, ~v, v ^ 8'h5A};
    for (i = 0; i < 3; i++) begin
      rnd(v);
      tl[8*i +: 8] = v;
      wr(8'h80 + 8'h10 * i, v);
    end
    chk("latches", {port2_latch_r, port1_latch_r, port0_latch_r}, tl);
    for (i = 0; i < 3; i++) rdchk(8'h80 + 8'h10 * i, ((td & tl) | (~td & ext_all)) >> (8 * i));
    wr(8'h86, 8'hFF);
    rdchk(8'h86, 8'h00);
    wr(8'h8E, 8'hFF);
    rdchk(8'h8E, 8'h07);
    rnd(acc_value);
    rnd(v);
    wr(8'hD0, v);
    rdchk(8'hD0, {v[7:1], ^acc_value});
    for (k = 0; k < 4; k++) begin
      wr(8'hD0, k << 3);
      chk("bank_base", {bank_select_r, 3'h0}, k * 8);
    end
    flag_we = 1;
    carry_in = 1;
    overflow_in = 1;
    @(negedge clk_sys);
    flag_we = 0;
    rdchk(8'hD0, {8'h9C | ^acc_value});
    pc_load_value = dp0;
    pc_load = 1;
    pc_fetch = 1;
    @(negedge clk_sys);
    pc_load = 0;
    pc_fetch = 0;
    chk("pc_load", program_counter_r, dp0);
    data_ptr0_sel = 1;
    repeat (2) @(negedge clk_sys);
    chk("code_index", code_index_addr_r, dp1 + acc_value);
    // Stretch 0, 3 and 6, both pointers, both directions
    for (k = 0; k < 8; k += 3) begin
      wr(8'h8E, k);
      data_ptr0_sel = k[0];
      rnd(xmem_wdata);
      xfer(0, k);
      xfer(1, k);
    end
    wr(8'h8E, 8'h01);
    xfer(1, 1);
    // Reset again in mid-run
    rst = 1;
    @(negedge clk_sys);
    rst = 0;
    rdchk(8'h81, 8'h07);
    rdchk(8'h8E, 8'h01);
    conclude;
  end
  // Watchdog, far beyond the fewer than two hundred cycles the run needs
  initial begin
    #(100 * 5000);
    error_cnt++;
    conclude;
  end
endmodule // tb
